// >>> hw/fpp_pkg.sv
package fpp_pkg;
  // File addresses decoded by the port block
  localparam int unsigned          ADDR_W           = 5;
  localparam logic [ADDR_W-1:0]    ADDR_STATUS      = 5'h03;
  localparam logic [ADDR_W-1:0]    ADDR_PORT        = 5'h06;

  localparam int unsigned          PINS             = 4;
  localparam int unsigned          DRV_PINS         = 3;

  // Reset values
  localparam logic [PINS-1:0]      DIR_RST          = 4'hF;
  localparam logic [7:0]           OPT_RST          = 8'hFF;
  localparam logic [PINS-1:0]      LATCH_POR        = 4'h0;

  // Field positions
  localparam int unsigned          STAT_PIN_WAKE    = 7;
  localparam int unsigned          STAT_CMP_WAKE    = 6;
  localparam int unsigned          OPT_PIN_WAKE_DIS = 7;
  localparam int unsigned          OPT_PULLUP_DIS   = 6;
  localparam int unsigned          OPT_TIMER_SRC    = 5;
  localparam int unsigned          PIN_TWO          = 2;

  // Owner of the shared pin two, Gray coded in priority order
  typedef enum logic [1:0] {
    OWN_OSC   = 2'h0,
    OWN_CMP   = 2'h1,
    OWN_TIMER = 2'h3,
    OWN_DIR   = 2'h2
  } fpp_pin2_owner_e;
endpackage

// >>> hw/fpp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         ce_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read by the second stage only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_in) begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule
`default_nettype wire

// >>> hw/fpp_port.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1 - Highest-priority active function owns shared pin
// RL2 - Pins zero-two bidirectional, pin three input-only
// RL3 - Direction zero drives latch, one floats pin
// RL4 - Output latch holds until next port write
// RL5 - Inputs unlatched, read returns present level
// RL6 - Port at 06h, upper four bits zero
// RL7 - Status bit seven marks pin-change wake reset
// RL8 - Status bit six marks comparator wake reset
// RL9 - Bit set/clear rewrites pin levels into latches
// RL10 - Write at cycle end, read at start
// RL11 - Software spaces port write and read
// RL12 - Outside never fights an actively driven pin
// RL13 - Reads return pins, never latch contents
// RL14 - Direction write-only, all ones on reset
// RL15 - Direction loaded whole from working register
// RL16 - Latches survive non-power-on resets
module fpp_port
  import fpp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  input  wire logic                        ce_in,
  // Reset cause from reset logic, same clock
  input  wire logic                        por_cause_in,
  input  wire logic                        pin_wake_cause_in,
  input  wire logic                        cmp_wake_cause_in,
  // Core file access
  input  wire logic [fpp_pkg::ADDR_W-1:0]  file_addr_in,
  input  wire logic                        file_rd_in,
  input  wire logic                        file_wr_in,
  input  wire logic [7:0]                  file_wdata_in,
  output logic      [7:0]                  file_rdata_out,
  // Bit set/clear on a file
  input  wire logic                        bit_op_in,
  input  wire logic                        bit_set_in,
  input  wire logic [2:0]                  bit_num_in,
  // Direction and option loads from working register
  input  wire logic                        dir_load_in,
  input  wire logic                        opt_load_in,
  input  wire logic [7:0]                  working_in,
  // Overrides from neighbouring functions
  input  wire logic                        osc_quarter_en_in,
  input  wire logic                        osc_quarter_in,
  input  wire logic                        cmp_out_en_in,
  input  wire logic                        comparator_output_in,
  input  wire logic                        cmp_inputs_en_in,
  // Pins
  input  wire logic [fpp_pkg::PINS-1:0]    pin_level_in,
  output logic      [fpp_pkg::DRV_PINS-1:0] pin_out,
  output logic      [fpp_pkg::DRV_PINS-1:0] pin_oe_out,
  // Option bits for timer and pin features
  output logic      [7:0]                  option_out
);
  import fpp_pkg::*;

  logic [PINS-1:0]     pins_sync;
  logic                first_q;
  logic [PINS-1:0]     latch_q;
  logic [PINS-1:0]     latch_d;
  logic [PINS-1:0]     dir_q;
  logic [PINS-1:0]     dir_d;
  logic [7:0]          opt_q;
  logic [7:0]          opt_d;
  logic                pin_wake_flag_q;
  logic                cmp_wake_flag_q;
  logic [7:0]          rdata_q;
  logic [DRV_PINS-1:0] drv_q;
  logic [DRV_PINS-1:0] drv_d;
  logic [DRV_PINS-1:0] oe_q;
  logic [DRV_PINS-1:0] oe_d;
  fpp_pin2_owner_e     owner2;
  logic                port_wr;
  logic                port_bitop;
  logic [7:0]          rmw_byte;

  // Read-modify-write of one bit over a full byte
  function automatic logic [7:0] bit_modify(input logic [7:0] val,
                                            input logic [2:0] num,
                                            input logic       set);
    logic [7:0] res;
    res      = val;
    res[num] = set;
    return res;
  endfunction

  function automatic logic [7:0] port_byte(input logic [PINS-1:0] p);
    return {4'h0, p};
  endfunction

  // Pins are asynchronous to this clock
  fpp_sync #(
    .W (PINS)
  ) u_pin_sync (
    .clk_in    (ref_clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .d_in      (pin_level_in),
    .q_out     (pins_sync)
  );

  assign port_wr    = file_wr_in && (file_addr_in == ADDR_PORT);
  assign port_bitop = bit_op_in && (file_addr_in == ADDR_PORT);
  assign rmw_byte   = bit_modify(port_byte(pins_sync), bit_num_in, bit_set_in);

  // First enabled edge after release; reset cause is caught here
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_q <= 1'b1;
    end else if (ce_in) begin
      first_q <= 1'b0;
    end
  end

  // Output latch: no async reset so other resets leave it alone
  always_comb begin
    latch_d = latch_q;
    if (first_q && por_cause_in) begin
      latch_d = LATCH_POR; // RL16
    end else if (port_bitop) begin
      // Pin levels, not latch contents, are written back
      latch_d = rmw_byte[PINS-1:0]; // RL9
    end else if (port_wr) begin
      latch_d = file_wdata_in[PINS-1:0]; // RL4
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (ce_in) begin
      latch_q <= latch_d; // RL4 RL16
    end
  end

  always_comb begin
    dir_d = dir_q;
    if (dir_load_in) begin
      dir_d = working_in[PINS-1:0]; // RL15
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_q <= DIR_RST; // RL14
    end else if (ce_in) begin
      dir_q <= dir_d;
    end
  end

  always_comb begin
    opt_d = opt_q;
    if (opt_load_in) begin
      opt_d = working_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      opt_q <= OPT_RST;
    end else if (ce_in) begin
      opt_q <= opt_d;
    end
  end

  // Wake cause flags; async reset clears, then the cause is loaded
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_wake_flag_q <= 1'b0;
      cmp_wake_flag_q <= 1'b0;
    end else if (ce_in && first_q) begin
      pin_wake_flag_q <= pin_wake_cause_in; // RL7
      cmp_wake_flag_q <= cmp_wake_cause_in; // RL8
    end
  end

  // Read samples pins at the start of the cycle, the edge that takes it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 8'h00;
    end else if (ce_in && file_rd_in) begin
      unique case (file_addr_in)
        ADDR_PORT: begin
          rdata_q <= port_byte(pins_sync); // RL5 RL6 RL10 RL13
        end
        ADDR_STATUS: begin
          rdata_q <= {pin_wake_flag_q, cmp_wake_flag_q, 6'h00}; // RL7 RL8
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // Pin two ownership in fixed priority
  always_comb begin
    if (osc_quarter_en_in) begin
      owner2 = OWN_OSC; // RL1
    end else if (cmp_out_en_in) begin
      owner2 = OWN_CMP; // RL1
    end else if (opt_d[OPT_TIMER_SRC]) begin
      owner2 = OWN_TIMER; // RL1
    end else begin
      owner2 = OWN_DIR;
    end
  end

  // Drivers follow next-state values so a write reaches pins at cycle end
  always_comb begin
    drv_d = latch_d[DRV_PINS-1:0];
    oe_d  = ~dir_d[DRV_PINS-1:0]; // RL3
    if (cmp_inputs_en_in) begin
      oe_d[1:0] = 2'b00; // RL1
    end
    unique case (owner2)
      OWN_OSC: begin
        drv_d[PIN_TWO] = osc_quarter_in;
        oe_d[PIN_TWO]  = 1'b1;
      end
      OWN_CMP: begin
        drv_d[PIN_TWO] = comparator_output_in;
        oe_d[PIN_TWO]  = 1'b1;
      end
      OWN_TIMER: begin
        oe_d[PIN_TWO]  = 1'b0;
      end
      OWN_DIR: begin
      end
    endcase
  end

  // Pin three has no driver at all; it is input or master clear only
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drv_q <= '0;
      oe_q  <= '0; // RL14
    end else if (ce_in) begin
      drv_q <= drv_d; // RL10
      oe_q  <= oe_d;  // RL2 RL3
    end
  end

  assign file_rdata_out = rdata_q;
  assign pin_out        = drv_q;
  assign pin_oe_out     = oe_q;
  assign option_out     = opt_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  port_read_a: assert property ( // RL13
    ce_in && file_rd_in && file_addr_in == ADDR_PORT
    |=> file_rdata_out == {4'h0, $past(pins_sync)})
    else $error("port read does not return pin levels");

  status_read_a: assert property ( // RL7
    ce_in && file_rd_in && file_addr_in == ADDR_STATUS
    |=> file_rdata_out == {$past(pin_wake_flag_q), $past(cmp_wake_flag_q), 6'h00})
    else $error("status read shows wrong wake flags");

  flag_load_a: assert property ( // RL8
    ce_in && first_q
    |=> (pin_wake_flag_q == $past(pin_wake_cause_in)
         && cmp_wake_flag_q == $past(cmp_wake_cause_in))
        ##1 ($stable(pin_wake_flag_q) && $stable(cmp_wake_flag_q)))
    else $error("wake flags not loaded from reset cause");

  dir_reset_a: assert property ( // RL14
    first_q |-> dir_q == DIR_RST && pin_oe_out == 3'b000)
    else $error("direction not all ones after reset");

  dir_load_a: assert property ( // RL15
    ce_in && dir_load_in |=> dir_q == $past(working_in[3:0]))
    else $error("direction not loaded from working value");

  latch_hold_a: assert property ( // RL4
    ce_in && !first_q && !port_wr && !port_bitop |=> $stable(latch_q))
    else $error("output latch changed without a write");

  latch_write_a: assert property ( // RL10
    ce_in && !first_q && port_wr && !port_bitop
    |=> latch_q == $past(file_wdata_in[3:0]))
    else $error("port write not latched at cycle end");

  rmw_a: assert property ( // RL9
    ce_in && !first_q && port_bitop && bit_num_in < 3'h4
    |=> latch_q[$past(bit_num_in[1:0])] == $past(bit_set_in)
        && (latch_q | (4'h1 << $past(bit_num_in[1:0])))
           == ($past(pins_sync) | (4'h1 << $past(bit_num_in[1:0]))))
    else $error("bit operation did not rewrite pin levels");

  osc_wins_a: assert property ( // RL1
    ce_in && osc_quarter_en_in
    |=> pin_oe_out[2] && pin_out[2] == $past(osc_quarter_in))
    else $error("oscillator output does not own pin two");

  cmp_in_a: assert property ( // RL1
    ce_in && cmp_inputs_en_in |=> pin_oe_out[1:0] == 2'b00)
    else $error("comparator inputs still driven");

  dir_drive_a: assert property ( // RL3
    ce_in && !cmp_inputs_en_in
    |=> pin_oe_out[1:0] == ~dir_q[1:0] && pin_out[1:0] == latch_q[1:0])
    else $error("pin driver does not follow direction and latch");

  cover_rmw_c: cover property (ce_in && port_bitop ##1 ce_in && port_bitop);
  cover_wr_rd_c: cover property (ce_in && port_wr ##2 ce_in && file_rd_in);
  cover_osc_c: cover property (ce_in && osc_quarter_en_in && cmp_out_en_in);
  cover_wake_c: cover property (ce_in && first_q && pin_wake_cause_in);
endmodule
`default_nettype wire

// >>> bench/fpp_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpp_pin_model (
  // From the port
  input  wire logic [2:0] drv_in,
  input  wire logic [2:0] oe_in,
  // Board drivers
  input  wire logic [3:0] ext_en_in,
  input  wire logic [3:0] ext_val_in,
  // Resolved pin levels
  output logic      [3:0] level_out
);
  always_comb begin
    level_out = 4'hF;
    for (int i = 0; i < 3; i++) begin
      if (oe_in[i]) begin
        level_out[i] = drv_in[i];
      end else if (ext_en_in[i]) begin
        // Board only drives where the port has let go
        level_out[i] = ext_val_in[i];
      end
    end
    // No pull-up on pin two: floats away from last drive
    if (!oe_in[2] && !ext_en_in[2]) begin
      level_out[2] = ~drv_in[2];
    end
    // Pin three is input only
    if (ext_en_in[3]) begin
      level_out[3] = ext_val_in[3];
    end
  end
endmodule
`default_nettype wire

// >>> bench/four_pin_port_with_priority_mux_tb.sv
`timescale 1ns/100ps
`default_nettype none
module four_pin_port_with_priority_mux_tb;
  import fpp_pkg::*;
  logic       clk = 0, rst_n = 0, por = 0, pwk = 0, cwk = 0, rd = 0, wr = 0;
  logic       bop = 0, bset = 0, dld = 0, old = 0, oen = 0, osc = 0;
  logic       cen = 0, cmp = 0, cin = 0, rtk = 0, ce = 1;
  logic [4:0] adr = 0;
  logic [7:0] wd = 0, wk = 0, rdat, opt;
  logic [2:0] bn = 0, po, poe;
  logic [3:0] xen = 0, xv = 0, lvl;
  logic [31:0] v;
  logic [7:0] q[$];
  int         errors = 0, compares = 0, seed = 32'hCA9A;

  always #4 clk = ~clk;

  fpp_port uut (.ref_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce),
    .por_cause_in(por), .pin_wake_cause_in(pwk), .cmp_wake_cause_in(cwk),
    .file_addr_in(adr), .file_rd_in(rd), .file_wr_in(wr), .file_wdata_in(wd),
    .file_rdata_out(rdat), .bit_op_in(bop), .bit_set_in(bset), .bit_num_in(bn),
    .dir_load_in(dld), .opt_load_in(old), .working_in(wk),
    .osc_quarter_en_in(oen), .osc_quarter_in(osc), .cmp_out_en_in(cen),
    .comparator_output_in(cmp), .cmp_inputs_en_in(cin), .pin_level_in(lvl),
    .pin_out(po), .pin_oe_out(poe), .option_out(opt));

  fpp_pin_model board (.drv_in(po), .oe_in(poe), .ext_en_in(xen),
    .ext_val_in(xv), .level_out(lvl));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Leave the pin synchroniser time to settle before sampling
  task automatic rd_t(input logic [4:0] a, input logic [7:0] e);
    cyc(4);
    q.push_back(e);
    adr = a;
    rd = 1;
    cyc(1);
    rd = 0;
  endtask

  task automatic wr_t(input logic [4:0] a, input logic [7:0] d);
    adr = a;
    wd = d;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask

  task automatic ld(input logic dir, input logic [7:0] w);
    wk = w;
    dld = dir;
    old = ~dir;
    cyc(1);
    dld = 0;
    old = 0;
    cyc(1);
  endtask

  task automatic bit_t(input logic s, input logic [2:0] n);
    adr = 5'h06;
    bset = s;
    bn = n;
    bop = 1;
    cyc(1);
    bop = 0;
    cyc(1);
  endtask

  task automatic rst_t(input logic p, input logic w, input logic c);
    por = p;
    pwk = w;
    cwk = c;
    rst_n = 0;
    cyc(12);
    rst_n = 1;
    cyc(3);
    {por, pwk, cwk} = 3'h0;
  endtask

  always @(posedge clk) rtk <= rd;
  always @(negedge clk) if (rtk && q.size() > 0) chk(rdat, q.pop_front());

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    rst_t(1, 0, 0);
    chk(8'(poe), 8'h00);
    chk(opt, 8'hFF);
    rd_t(5'h03, 8'h00);
    xen = 4'hF;
    xv = 4'hA;
    rd_t(5'h06, 8'h0A);
    xen = 0;
    rd_t(5'h10, 8'h00);
    wr_t(5'h03, 8'hFF);
    rd_t(5'h03, 8'h00);
    ld(1, 8'hF0);
    chk(8'(poe), 8'h03);
    ld(0, 8'hDF);
    chk(8'(poe), 8'h07);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      xen = 4'h8;
      xv = v[7:4];
      wr_t(5'h06, v[7:0]);
      chk(8'(po), 8'(v[2:0]));
      rd_t(5'h06, {4'h0, v[7], v[2:0]});
      chk(8'(po), 8'(v[2:0]));
    end
    wr_t(5'h06, 8'h01);
    ld(1, 8'h01);
    xv = 4'h0;
    xen = 4'h1;
    cyc(3);
    bit_t(1, 2);
    xen = 0;
    ld(1, 8'h00);
    chk(8'(po), 8'h04);
    cyc(3);
    bit_t(0, 2);
    chk(8'(po), 8'h00);
    // Enable low: write and load must both be ignored
    ce = 0;
    wr_t(5'h06, 8'h07);
    ld(1, 8'hFF);
    chk(8'(po), 8'h00);
    chk(8'(poe), 8'h07);
    ce = 1;
    wr_t(5'h06, 8'h04);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      osc = v[0];
      cmp = v[1];
      oen = (i == 0);
      cen = (i < 2);
      cin = (i == 0);
      ld(0, (i < 3) ? 8'hFF : 8'hDF);
      chk(opt, (i < 3) ? 8'hFF : 8'hDF);
      cyc(1);
      chk(8'(poe), 8'({i != 2, {2{i != 0}}}));
      if (i != 2) chk(8'(po[2]), 8'(i == 0 ? v[0] : i == 1 ? v[1] : 1'b1));
    end
    {oen, cen, cin} = 3'h0;
    wr_t(5'h06, 8'h05);
    rst_t(0, 1, 0);
    chk(8'(poe), 8'h00);
    rd_t(5'h03, 8'h80);
    ld(1, 8'h00);
    chk(8'(po), 8'h05);
    rst_t(0, 0, 1);
    rd_t(5'h03, 8'h40);
    rst_t(0, 0, 0);
    rd_t(5'h03, 8'h00);
    cyc(3);
    chk(8'(q.size()), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
